/* buckc4_cfg.svh */
// register indices, field positions and reset values of the fourth converter control block
`ifndef BUCKC4_CFG_SVH
`define BUCKC4_CFG_SVH
// register indices; byte address is four times the index
`define BUCKC4_IDX_CTRL 8'hbd
`define BUCKC4_IDX_SEQ 8'hbe
`define BUCKC4_IDX_SLEEP 8'hbf
`define BUCKC4_IDX_STAT 8'hc8
`define BUCKC4_IDX_MASK 8'hc9
`define BUCKC4_ADDR_W 10
// control register fields
`define BUCKC4_FLOAT_BIT 10
`define BUCKC4_VSEL_LSB 0
// sequencing register fields
`define BUCKC4_FACT_LSB 14
`define BUCKC4_ENSLOT_LSB 10
`define BUCKC4_SDSLOT_LSB 6
// sleep register fields
`define BUCKC4_SBEH_LSB 12
`define BUCKC4_STRIG_LSB 8
`define BUCKC4_VIMG_LSB 0
// status and mask bits
`define BUCKC4_EV_FAULT 0
`define BUCKC4_EV_SLEEP_IN 1
`define BUCKC4_EV_SLEEP_OUT 2
// slot codes
`define BUCKC4_SLOT_NONE 4'h0
`define BUCKC4_SLOT_EDGE 4'hf
// reset values
`define BUCKC4_RST_FLOAT 1'h0
`define BUCKC4_RST_FACT 2'h0
`define BUCKC4_RST_SDSLOT 4'h0
`define BUCKC4_RST_SBEH 3'h0
`define BUCKC4_RST_STRIG 2'h0
`define BUCKC4_RST_VIMG 7'h06
// per-variant defaults of the voltage code and start-up slot, variants 0 to 3
`define BUCKC4_VSEL_V0 7'h00
`define BUCKC4_VSEL_V1 7'h56
`define BUCKC4_VSEL_V2 7'h0e
`define BUCKC4_VSEL_V3 7'h06
`define BUCKC4_ENSLOT_V0 4'h0
`define BUCKC4_ENSLOT_V1 4'h1
`define BUCKC4_ENSLOT_V2 4'h0
`define BUCKC4_ENSLOT_V3 4'h3
`endif

/* buckc4_pkg.sv */
// types of the fourth converter control block
package buckc4_pkg;
    typedef enum logic [2:0] {
        BEH_KEEP = 3'b000,
        BEH_IMAGE = 3'b001,
        BEH_STBY = 3'b010,
        BEH_STBY_IMAGE = 3'b011,
        BEH_LIN = 3'b100,
        BEH_LIN_IMAGE = 3'b101,
        BEH_RSVD = 3'b110,
        BEH_OFF = 3'b111
    } buckc4_sleep_e;
    typedef enum logic [1:0] {
        FACT_IGNORE = 2'b00,
        FACT_CONV = 2'b01,
        FACT_SYS = 2'b10,
        FACT_SYS_RSVD = 2'b11
    } buckc4_fact_e;
endpackage : buckc4_pkg

/* buckc4_sync.sv */
// two-stage synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module buckc4_sync #(
    parameter int W = 1
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] meta_r;
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            meta_r <= '0;
            dout <= '0;
        end else begin
            meta_r <= din;
            dout <= meta_r;
        end
    end
endmodule : buckc4_sync
`default_nettype wire

/* buckc4_ctrl.sv */
// register and sequencing logic of the fourth buck converter, APB slave
//
// What this block does
// - discharge output when disabled unless float set
// - 7-bit voltage code, 25mV steps from 0.85V
// - fault raises interrupt, then ignore/convert/system shutdown
// - start-up slot: never, slot 1-14, on active
// - shutdown slot 1-14, else on entering off
// - sleep keeps, takes image, or disables output
// - sleep forces standby or linear, optionally image
// - sleep trigger from request bit or low-power inputs
// - gpio sleep input always enters sleep
// - separate image voltage code, same encoding
// - power state machine restores variant defaults
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "buckc4_cfg.svh"
module buckc4_ctrl
    import buckc4_pkg::*;
#(
    parameter int VARIANT = 0
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`BUCKC4_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // power state machine, same clock
    input wire logic smDefaults,
    input wire logic seqStartStrobe,
    input wire logic seqStopStrobe,
    input wire logic [3:0] seqSlot,
    input wire logic enterActive,
    input wire logic enterOff,
    input wire logic sleepReqBit,
    // pins
    input wire logic [2:0] lowPowerIn,
    input wire logic gpioSleepIn,
    input wire logic convFaultIn,
    // converter controls
    output logic convEnable,
    output logic outputDischarge,
    output logic [6:0] voltageCode,
    output logic modeStandby,
    output logic modeLinear,
    output logic sleepActive,
    output logic systemShutdown,
    output logic irq
);
    localparam logic [6:0] DEF_VSEL = (VARIANT == 1) ? `BUCKC4_VSEL_V1 :
        (VARIANT == 2) ? `BUCKC4_VSEL_V2 : (VARIANT == 3) ? `BUCKC4_VSEL_V3 : `BUCKC4_VSEL_V0;
    localparam logic [3:0] DEF_ENSLOT = (VARIANT == 1) ? `BUCKC4_ENSLOT_V1 :
        (VARIANT == 2) ? `BUCKC4_ENSLOT_V2 : (VARIANT == 3) ? `BUCKC4_ENSLOT_V3 :
        `BUCKC4_ENSLOT_V0;

    logic outputFloat_r;
    logic [6:0] outputVoltageCode_r;
    buckc4_fact_e faultAction_r;
    logic [3:0] startupSlot_r;
    logic [3:0] shutdownSlot_r;
    buckc4_sleep_e sleepBehaviour_r;
    logic [1:0] sleepTriggerSelect_r;
    logic [6:0] imageVoltageCode_r;
    logic [2:0] status_r;
    logic [2:0] mask_r;
    logic [2:0] lowPowerS;
    logic gpioSleepS;
    logic faultS;
    logic faultPrev_r;

    buckc4_sync #(.W(5)) uSync (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .din({convFaultIn, gpioSleepIn, lowPowerIn}),
        .dout({faultS, gpioSleepS, lowPowerS})
    );

    // apb decode; one wait state so every answer comes from a flip-flop
    logic [7:0] regIdx;
    logic accessDone;
    logic wrDone;
    logic rdDone;
    logic mapped;
    assign regIdx = paddr[`BUCKC4_ADDR_W-1:2];
    assign accessDone = psel && penable && pready;
    assign wrDone = accessDone && pwrite && mapped;
    assign rdDone = accessDone && !pwrite && mapped;
    assign mapped = (paddr[1:0] == 2'h0) && (regIdx == `BUCKC4_IDX_CTRL ||
        regIdx == `BUCKC4_IDX_SEQ || regIdx == `BUCKC4_IDX_SLEEP ||
        regIdx == `BUCKC4_IDX_STAT || regIdx == `BUCKC4_IDX_MASK);

    logic [31:0] rdData;
    always_comb begin
        rdData = 32'h0;
        unique case (regIdx)
            `BUCKC4_IDX_CTRL: begin
                rdData[`BUCKC4_FLOAT_BIT] = outputFloat_r;
                rdData[`BUCKC4_VSEL_LSB +: 7] = outputVoltageCode_r;
            end
            `BUCKC4_IDX_SEQ: begin
                rdData[`BUCKC4_FACT_LSB +: 2] = faultAction_r;
                rdData[`BUCKC4_ENSLOT_LSB +: 4] = startupSlot_r;
                rdData[`BUCKC4_SDSLOT_LSB +: 4] = shutdownSlot_r;
            end
            `BUCKC4_IDX_SLEEP: begin
                rdData[`BUCKC4_SBEH_LSB +: 3] = sleepBehaviour_r;
                rdData[`BUCKC4_STRIG_LSB +: 2] = sleepTriggerSelect_r;
                rdData[`BUCKC4_VIMG_LSB +: 7] = imageVoltageCode_r;
            end
            `BUCKC4_IDX_STAT: rdData[2:0] = status_r;
            `BUCKC4_IDX_MASK: rdData[2:0] = mask_r;
            default: rdData = 32'h0;
        endcase
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            pready <= 1'b0;
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && penable && !pready;
            prdata <= (psel && penable && !pready && !pwrite) ? rdData : 32'h0;
            pslverr <= psel && penable && !pready && !mapped;
        end
    end

    // software fields; the state machine's default request outranks a write
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            outputFloat_r <= `BUCKC4_RST_FLOAT;
            outputVoltageCode_r <= DEF_VSEL;
            faultAction_r <= buckc4_fact_e'(`BUCKC4_RST_FACT);
            startupSlot_r <= DEF_ENSLOT;
            shutdownSlot_r <= `BUCKC4_RST_SDSLOT;
            sleepBehaviour_r <= buckc4_sleep_e'(`BUCKC4_RST_SBEH);
            sleepTriggerSelect_r <= `BUCKC4_RST_STRIG;
            imageVoltageCode_r <= `BUCKC4_RST_VIMG;
            mask_r <= 3'h0;
        end else if (smDefaults) begin
            outputFloat_r <= `BUCKC4_RST_FLOAT;
            outputVoltageCode_r <= DEF_VSEL;
            faultAction_r <= buckc4_fact_e'(`BUCKC4_RST_FACT);
            startupSlot_r <= DEF_ENSLOT;
            shutdownSlot_r <= `BUCKC4_RST_SDSLOT;
            sleepBehaviour_r <= buckc4_sleep_e'(`BUCKC4_RST_SBEH);
            sleepTriggerSelect_r <= `BUCKC4_RST_STRIG;
            imageVoltageCode_r <= `BUCKC4_RST_VIMG;
        end else if (wrDone) begin
            unique case (regIdx)
                `BUCKC4_IDX_CTRL: begin
                    outputFloat_r <= pwdata[`BUCKC4_FLOAT_BIT];
                    outputVoltageCode_r <= pwdata[`BUCKC4_VSEL_LSB +: 7];
                end
                `BUCKC4_IDX_SEQ: begin
                    faultAction_r <= buckc4_fact_e'(pwdata[`BUCKC4_FACT_LSB +: 2]);
                    startupSlot_r <= pwdata[`BUCKC4_ENSLOT_LSB +: 4];
                    shutdownSlot_r <= pwdata[`BUCKC4_SDSLOT_LSB +: 4];
                end
                `BUCKC4_IDX_SLEEP: begin
                    sleepBehaviour_r <= buckc4_sleep_e'(pwdata[`BUCKC4_SBEH_LSB +: 3]);
                    sleepTriggerSelect_r <= pwdata[`BUCKC4_STRIG_LSB +: 2];
                    imageVoltageCode_r <= pwdata[`BUCKC4_VIMG_LSB +: 7];
                end
                `BUCKC4_IDX_MASK: mask_r <= pwdata[2:0];
                default: ;
            endcase
        end
    end

    // fault edge and its action
    logic faultEv;
    logic faultConv;
    logic faultSys;
    assign faultEv = faultS && !faultPrev_r;
    assign faultConv = faultEv && faultAction_r == FACT_CONV;
    assign faultSys = faultEv && faultAction_r[1];
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            faultPrev_r <= 1'b0;
        end else begin
            faultPrev_r <= faultS;
        end
    end

    // sleep source; gpio sleep cannot be masked by the selector
    logic sleepTrig;
    logic sleepNxt;
    always_comb begin
        unique case (sleepTriggerSelect_r)
            2'h0: sleepTrig = sleepReqBit;
            2'h1: sleepTrig = lowPowerS[0];
            2'h2: sleepTrig = lowPowerS[1];
            default: sleepTrig = lowPowerS[2];
        endcase
        sleepNxt = sleepTrig || gpioSleepS;
    end

    // enable sequencing; stop and fault outrank start in the same cycle
    logic slotIsNum;
    logic startHit;
    logic stopHit;
    logic convOnNxt;
    logic convOn_r;
    assign slotIsNum = seqSlot != `BUCKC4_SLOT_NONE && seqSlot != `BUCKC4_SLOT_EDGE;
    assign startHit = (seqStartStrobe && slotIsNum && seqSlot == startupSlot_r) ||
        (enterActive && startupSlot_r == `BUCKC4_SLOT_EDGE);
    assign stopHit = (seqStopStrobe && slotIsNum && seqSlot == shutdownSlot_r) ||
        (enterOff && (shutdownSlot_r == `BUCKC4_SLOT_NONE ||
        shutdownSlot_r == `BUCKC4_SLOT_EDGE));
    always_comb begin
        convOnNxt = convOn_r;
        if (startHit) begin
            convOnNxt = 1'b1;
        end
        if (stopHit || faultConv || faultSys) begin
            convOnNxt = 1'b0;
        end
    end

    // sleep behaviour folded into what the converter sees
    logic useImage;
    logic stbyNxt;
    logic linNxt;
    logic sleepOff;
    always_comb begin
        useImage = 1'b0;
        stbyNxt = 1'b0;
        linNxt = 1'b0;
        sleepOff = 1'b0;
        if (sleepNxt) begin
            unique case (sleepBehaviour_r)
                BEH_IMAGE: useImage = 1'b1;
                BEH_STBY: stbyNxt = 1'b1;
                BEH_STBY_IMAGE: begin
                    stbyNxt = 1'b1;
                    useImage = 1'b1;
                end
                BEH_LIN: linNxt = 1'b1;
                BEH_LIN_IMAGE: begin
                    linNxt = 1'b1;
                    useImage = 1'b1;
                end
                BEH_OFF: sleepOff = 1'b1;
                default: ; // reserved code behaves as no change
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            convOn_r <= 1'b0;
            convEnable <= 1'b0;
            outputDischarge <= 1'b1;
            voltageCode <= 7'h0;
            modeStandby <= 1'b0;
            modeLinear <= 1'b0;
            sleepActive <= 1'b0;
            systemShutdown <= 1'b0;
        end else begin
            convOn_r <= convOnNxt;
            convEnable <= convOnNxt && !sleepOff;
            outputDischarge <= !(convOnNxt && !sleepOff) && !outputFloat_r;
            voltageCode <= useImage ? imageVoltageCode_r : outputVoltageCode_r;
            modeStandby <= stbyNxt;
            modeLinear <= linNxt;
            sleepActive <= sleepNxt;
            systemShutdown <= faultSys;
        end
    end

    // sticky events, cleared by a read of the status word; a new event wins
    logic [2:0] evNow;
    assign evNow = {sleepActive && !sleepNxt, sleepNxt && !sleepActive, faultEv};
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            status_r <= 3'h0;
            irq <= 1'b0;
        end else begin
            status_r <= (status_r & ~((rdDone && regIdx == `BUCKC4_IDX_STAT) ? 3'h7 : 3'h0))
                | evNow;
            irq <= |(((status_r & ~((rdDone && regIdx == `BUCKC4_IDX_STAT) ? 3'h7 : 3'h0))
                | evNow) & mask_r);
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    sequence faultSysSeq;
        faultEv && faultAction_r[1];
    endsequence
    sequence gpioRiseSeq;
        $rose(gpioSleepS);
    endsequence

    chk_float_discharge: assert property ($fell(convEnable) && !$past(outputFloat_r)
        |-> outputDischarge) else $error("output not discharged on disable");
    chk_voltage_normal: assert property (!sleepActive && $past(nrst) |-> voltageCode ==
        $past(outputVoltageCode_r)) else $error("normal voltage code not applied");
    chk_fault_conv: assert property (faultEv && faultAction_r == FACT_CONV
        |=> !convEnable) else $error("fault did not stop converter");
    chk_fault_system: assert property (faultSysSeq |=> systemShutdown ##1 !systemShutdown)
        else $error("fault did not shut system once");
    chk_fault_irq: assert property (faultEv && mask_r[`BUCKC4_EV_FAULT] |=> irq)
        else $error("fault did not raise interrupt");
    chk_start_slot: assert property (seqStartStrobe && slotIsNum && seqSlot == startupSlot_r
        && !stopHit && !faultEv && !sleepOff |=> convEnable)
        else $error("start slot missed");
    chk_stop_off: assert property (enterOff && shutdownSlot_r == `BUCKC4_SLOT_NONE
        |=> !convEnable) else $error("not stopped entering off");
    chk_sleep_standby: assert property (modeStandby |-> sleepActive &&
        ($past(sleepBehaviour_r) == BEH_STBY || $past(sleepBehaviour_r) == BEH_STBY_IMAGE))
        else $error("standby forced wrongly");
    chk_gpio_sleep: assert property (gpioRiseSeq |=> sleepActive)
        else $error("gpio sleep ignored");
    chk_wake_restore: assert property (!sleepActive |-> !modeStandby && !modeLinear)
        else $error("mode kept after sleep");
    chk_sm_default: assert property (smDefaults |=> outputVoltageCode_r == DEF_VSEL
        && startupSlot_r == DEF_ENSLOT) else $error("defaults not restored");
endmodule : buckc4_ctrl
`default_nettype wire

/* test_buckc4_ctrl.sv */
// self-checking testbench of the fourth converter control block
`timescale 1ns/1ps
`default_nettype none
`include "buckc4_cfg.svh"
module test_buckc4_ctrl
    import buckc4_pkg::*;
;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [9:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata;
    logic pready, pslverr;
    logic smDefaults = 1'b0, seqStartStrobe = 1'b0, seqStopStrobe = 1'b0;
    logic enterActive = 1'b0, enterOff = 1'b0, sleepReqBit = 1'b0;
    logic [3:0] seqSlot = '0;
    logic [2:0] lowPowerIn = '0;
    logic gpioSleepIn = 1'b0, convFaultIn = 1'b0;
    logic convEnable, outputDischarge, modeStandby, modeLinear;
    logic sleepActive, systemShutdown, irq;
    logic [6:0] voltageCode;
    int num_errors = 0;
    int check_count = 0;

    always #12.5 clk_sys = ~clk_sys;

    buckc4_ctrl #(.VARIANT(1)) dut (
        .clk_sys(clk_sys), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .smDefaults(smDefaults), .seqStartStrobe(seqStartStrobe), .seqStopStrobe(seqStopStrobe),
        .seqSlot(seqSlot), .enterActive(enterActive), .enterOff(enterOff),
        .sleepReqBit(sleepReqBit), .lowPowerIn(lowPowerIn), .gpioSleepIn(gpioSleepIn),
        .convFaultIn(convFaultIn), .convEnable(convEnable), .outputDischarge(outputDischarge),
        .voltageCode(voltageCode), .modeStandby(modeStandby), .modeLinear(modeLinear),
        .sleepActive(sleepActive), .systemShutdown(systemShutdown), .irq(irq)
    );

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : wrap_up

    task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_val

    task automatic chk_bit(input string what, input logic exp, input logic got);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
        end
    endtask : chk_bit

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : tick

    // one apb transfer; the request stands until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [1:0] off,
            input logic [31:0] wd, output logic [31:0] rd, output logic err);
        int n;
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, off};
        pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            num_errors++;
            $display("timeout waiting for pready");
            wrap_up();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
        logic [31:0] d;
        logic e;
        apb(1'b1, idx, 2'b00, wd, d, e);
        chk_bit("pslverr on write", 1'b0, e);
    endtask : wr

    task automatic rd_chk(input string what, input logic [7:0] idx, input logic [31:0] exp);
        logic [31:0] d;
        logic e;
        apb(1'b0, idx, 2'b00, 32'h0, d, e);
        chk_bit("pslverr on read", 1'b0, e);
        chk_val(what, exp, d);
    endtask : rd_chk

    // writes the sequencing register, then gives one sequencer pulse of kind k
    task automatic seq_step(input logic [15:0] sw, input int k, input logic [3:0] s,
            input logic exp);
        wr(`BUCKC4_IDX_SEQ, {16'h0, sw});
        @(posedge clk_sys);
        seqStartStrobe <= (k == 0);
        seqStopStrobe <= (k == 1);
        enterActive <= (k == 2);
        enterOff <= (k == 3);
        seqSlot <= s;
        @(posedge clk_sys);
        seqStartStrobe <= 1'b0;
        seqStopStrobe <= 1'b0;
        enterActive <= 1'b0;
        enterOff <= 1'b0;
        tick(2);
        chk_bit("convEnable", exp, convEnable);
    endtask : seq_step

    initial begin
        #(25 * 60000);
        num_errors++;
        $display("run limit reached");
        wrap_up();
    end

    initial begin
        logic [31:0] d;
        logic e;
        logic img;
        logic seen;
        repeat (20) @(posedge clk_sys);
        nrst <= 1'b1;
        tick(1);
        chk_bit("discharge after reset", 1'b1, outputDischarge);
        rd_chk("ctrl default", `BUCKC4_IDX_CTRL, 32'h0000_0056);
        rd_chk("seq default", `BUCKC4_IDX_SEQ, 32'h0000_0400);
        rd_chk("sleep default", `BUCKC4_IDX_SLEEP, 32'h0000_0006);
        rd_chk("mask default", `BUCKC4_IDX_MASK, 32'h0);
        apb(1'b0, 8'h00, 2'b00, 32'h0, d, e);
        chk_bit("unmapped err", 1'b1, e);
        chk_val("unmapped data", 32'h0, d);
        apb(1'b1, `BUCKC4_IDX_CTRL, 2'b01, 32'h7f, d, e);
        chk_bit("misaligned err", 1'b1, e);
        rd_chk("ctrl kept", `BUCKC4_IDX_CTRL, 32'h0000_0056);
        wr(`BUCKC4_IDX_CTRL, 32'hffff_ffff);
        wr(`BUCKC4_IDX_SEQ, 32'hffff_ffff);
        wr(`BUCKC4_IDX_SLEEP, 32'hffff_ffff);
        wr(`BUCKC4_IDX_MASK, 32'h1);
        rd_chk("ctrl fields", `BUCKC4_IDX_CTRL, 32'h0000_047f);
        rd_chk("seq fields", `BUCKC4_IDX_SEQ, 32'h0000_ffc0);
        rd_chk("sleep fields", `BUCKC4_IDX_SLEEP, 32'h0000_737f);
        @(posedge clk_sys);
        smDefaults <= 1'b1;
        @(posedge clk_sys);
        smDefaults <= 1'b0;
        rd_chk("ctrl restored", `BUCKC4_IDX_CTRL, 32'h0000_0056);
        rd_chk("seq restored", `BUCKC4_IDX_SEQ, 32'h0000_0400);
        rd_chk("sleep restored", `BUCKC4_IDX_SLEEP, 32'h0000_0006);
        rd_chk("mask untouched", `BUCKC4_IDX_MASK, 32'h1);
        $display("test registers done");
        wr(`BUCKC4_IDX_CTRL, 32'h0000_0426);
        tick(2);
        chk_val("voltage code", 32'h26, {25'h0, voltageCode});
        chk_bit("floating output", 1'b0, outputDischarge);
        wr(`BUCKC4_IDX_CTRL, 32'h0000_0030);
        tick(2);
        chk_bit("discharged output", 1'b1, outputDischarge);
        $display("test output control done");
        seq_step(16'h0d40, 0, 4'd2, 1'b0);
        seq_step(16'h0d40, 0, 4'd3, 1'b1);
        chk_bit("no discharge while on", 1'b0, outputDischarge);
        seq_step(16'h0d40, 1, 4'd4, 1'b1);
        seq_step(16'h0d40, 1, 4'd5, 1'b0);
        seq_step(16'h3fc0, 2, 4'd0, 1'b1);
        seq_step(16'h3fc0, 3, 4'd0, 1'b0);
        seq_step(16'h3800, 0, 4'd14, 1'b1);
        seq_step(16'h3800, 3, 4'd0, 1'b0);
        seq_step(16'h0000, 0, 4'd1, 1'b0);
        seq_step(16'h0000, 2, 4'd0, 1'b0);
        $display("test sequencing done");
        for (int a = 0; a < 4; a++) begin
            seq_step({a[1:0], 14'h3fc0}, 2, 4'd0, 1'b1);
            apb(1'b0, `BUCKC4_IDX_STAT, 2'b00, 32'h0, d, e);
            @(posedge clk_sys);
            convFaultIn <= 1'b1;
            seen = 1'b0;
            for (int i = 0; i < 8; i++) begin
                tick(1);
                if (systemShutdown === 1'b1) seen = 1'b1;
            end
            chk_bit("system shutdown", a >= 2, seen);
            if (a < 2) chk_bit("fault convEnable", a == 0, convEnable);
            chk_bit("fault irq", 1'b1, irq);
            rd_chk("fault status", `BUCKC4_IDX_STAT, 32'h1);
            tick(2);
            chk_bit("irq cleared", 1'b0, irq);
            @(posedge clk_sys);
            convFaultIn <= 1'b0;
            tick(4);
        end
        $display("test fault actions done");
        seq_step(16'h3fc0, 2, 4'd0, 1'b1);
        for (int b = 0; b < 8; b++) begin
            wr(`BUCKC4_IDX_SLEEP, 32'h10 | (b << 12));
            img = (b == 1 || b == 3 || b == 5);
            @(posedge clk_sys);
            sleepReqBit <= 1'b1;
            tick(3);
            chk_bit("asleep", 1'b1, sleepActive);
            chk_val("sleep code", img ? 32'h10 : 32'h30, {25'h0, voltageCode});
            chk_bit("sleep standby", b == 2 || b == 3, modeStandby);
            chk_bit("sleep linear", b == 4 || b == 5, modeLinear);
            chk_bit("sleep enable", b != 7, convEnable);
            @(posedge clk_sys);
            sleepReqBit <= 1'b0;
            tick(3);
            chk_bit("awake", 1'b0, sleepActive);
            chk_val("awake code", 32'h30, {25'h0, voltageCode});
            chk_bit("awake modes", 1'b0, modeStandby | modeLinear);
            chk_bit("awake enable", 1'b1, convEnable);
        end
        $display("test sleep behaviour done");
        for (int t = 1; t < 4; t++) begin
            wr(`BUCKC4_IDX_SLEEP, 32'h2010 | (t << 8));
            @(posedge clk_sys);
            lowPowerIn <= 3'(1 << (t % 3));
            sleepReqBit <= 1'b1;
            tick(5);
            chk_bit("other trigger", 1'b0, sleepActive);
            @(posedge clk_sys);
            lowPowerIn <= 3'(1 << (t - 1));
            sleepReqBit <= 1'b0;
            tick(5);
            chk_bit("chosen trigger", 1'b1, sleepActive);
            chk_bit("trigger standby", 1'b1, modeStandby);
            @(posedge clk_sys);
            lowPowerIn <= 3'b000;
            tick(5);
            chk_bit("trigger gone", 1'b0, sleepActive);
        end
        wr(`BUCKC4_IDX_SLEEP, 32'h0110);
        wr(`BUCKC4_IDX_MASK, 32'h2);
        apb(1'b0, `BUCKC4_IDX_STAT, 2'b00, 32'h0, d, e);
        @(posedge clk_sys);
        gpioSleepIn <= 1'b1;
        tick(5);
        chk_bit("gpio sleep", 1'b1, sleepActive);
        chk_bit("sleep irq", 1'b1, irq);
        rd_chk("sleep status", `BUCKC4_IDX_STAT, 32'h2);
        @(posedge clk_sys);
        gpioSleepIn <= 1'b0;
        tick(5);
        chk_bit("gpio wake", 1'b0, sleepActive);
        chk_bit("masked irq", 1'b0, irq);
        rd_chk("wake status", `BUCKC4_IDX_STAT, 32'h4);
        $display("test sleep triggers done");
        wrap_up();
    end
endmodule : test_buckc4_ctrl
`default_nettype wire
